/* File: src/cbt_cfg.svh */
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH
// register offsets (byte addresses)
`define CBT_OFF_CTRL      8'h00
`define CBT_OFF_FAULT     8'h08
`define CBT_OFF_BTIME     8'h0C
`define CBT_OFF_IRQ_STAT  8'h20
`define CBT_OFF_IRQ_MASK  8'h24
// control register fields and reset
`define CBT_CTRL_INIT     0
`define CBT_CTRL_CCE      6
// bit timing register: reset value and top bit of the used field
`define CBT_BTIME_RST     15'h2301
`define CBT_BTIME_MSB     14
// fault counter register fields
`define CBT_TEC_MSB       7
`define CBT_REC_MSB       14
`define CBT_REC_LSB       8
`define CBT_RP_BIT        15
// fault confinement figures
`define CBT_TEC_STEP      8'h08
`define CBT_TEC_TOP_OK    8'hF7
`define CBT_TEC_MAX       8'hFF
`define CBT_REC_PASSIVE   8'h80
`define CBT_REC_MAJ_TOP   8'h78
`define CBT_REC_RELOAD    8'h77
`define CBT_WARN_LEVEL    8'h60
// interrupt status bits
`define CBT_IRQ_W         3
`define CBT_IRQ_RX_PASS   0
`define CBT_IRQ_WARN      1
`define CBT_IRQ_BUS_OFF   2
`endif

/* File: src/cbt_pkg.sv */
package cbt_pkg;
    // bit timing phase, one-hot
    typedef enum logic [2:0] {
        CBT_SYNC = 3'b001,
        CBT_SEG1 = 3'b010,
        CBT_SEG2 = 3'b100
    } cbt_phase_e;

    // bit timing register layout, bits 14..0
    typedef struct packed {
        logic [2:0] phase_after_sample;
        logic [3:0] phase_before_sample;
        logic [1:0] resync_jump_width;
        logic [5:0] quantum_prescaler;
    } cbt_btime_s;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cbt_bus_req_s;

    // bus events from the frame engine, one-cycle pulses
    typedef struct packed {
        logic tx_err;
        logic rx_err;
        logic rx_err_major;
        logic tx_ok;
        logic rx_ok;
    } cbt_err_ev_s;

    // whole state of the block
    typedef struct packed {
        logic        init;
        logic        config_change_enable;
        cbt_btime_s  btime;
        logic [7:0]  tx_fault_tally;
        logic [7:0]  rx_fault_tally;
        logic        bus_off;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic        rx_meta;
        logic        rx_sync;
        logic        rx_prev;
        logic [5:0]  presc;
        logic [4:0]  tq_cnt;
        logic [4:0]  seg_end;
        cbt_phase_e  phase;
        logic        resync_done;
        logic        rx_bit;
        logic        sample_pulse;
        logic        bit_start;
        logic [31:0] rdata;
    } cbt_state_s;
endpackage : cbt_pkg

/* File: src/cbt_top.sv */
// Notes on behaviour
// - the transmit fault tally reads as an 8-bit value 0..255 in bits 7..0 of fault_counters.
// - the receive fault tally reads as a 7-bit value 0..127 in bits 14..8 of fault_counters.
// - bit 15 is set while the receive tally is at or above error-passive, else clear.
// - bits 31..16 of fault_counters and 31..15 of bit_timing_config read zero; write zero.
// - the after-sample segment code in bits 14..12 gives a segment of code plus one quanta.
// - the before-sample code in bits 11..8 gives code plus one quanta; program 1..15 only.
// - the jump width code in bits 7..6 gives a jump width of code plus one quanta.
// - one time quantum is prescaler code in bits 5..0 plus one clocks; bits are whole quanta.
// - bit_timing_config resets to 0x2301 and fault_counters to zero.
// - timing writes are taken only while both init and config change enable are set.
//
// Our own choice: the plain strobed port.
`include "cbt_cfg.svh"

module cbt_top
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    // register port
    input  wire cbt_pkg::cbt_bus_req_s bus_req,
    output logic [31:0]               bus_rdata,
    // bus events from the frame engine
    input  wire cbt_pkg::cbt_err_ev_s  err_ev,
    // bus receive pin
    input  wire logic                 can_rx,
    // timing results to the frame engine
    output logic                      sample_pulse,
    output logic                      rx_bit,
    output logic                      bit_start,
    output logic                      tq_tick,
    // status
    output logic                      init,
    output logic                      bus_off,
    output logic                      irq
);

    localparam cbt_pkg::cbt_state_s ST_RST = '{
        init: 1'b1, btime: `CBT_BTIME_RST, phase: cbt_pkg::CBT_SYNC,
        rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1, default: '0};

    cbt_pkg::cbt_state_s st_r;
    cbt_pkg::cbt_state_s st_nxt;
    logic                edge_fall;
    logic [4:0]          jump;
    logic [4:0]          remain;
    logic [2:0]          ev;
    logic [2:0]          stat_clr;

    ////////////////////////////////////////////////////////////////////////////
    // quantum tick and resync edge; the prescaler is held while in init
    assign tq_tick   = ~st_r.init & (st_r.presc == st_r.btime.quantum_prescaler);
    assign edge_fall = st_r.rx_prev & ~st_r.rx_sync;
    assign jump      = {3'h0, st_r.btime.resync_jump_width} + 5'h01;
    assign remain    = st_r.seg_end - st_r.tq_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        st_nxt              = st_r;
        st_nxt.sample_pulse = 1'b0;
        st_nxt.bit_start    = 1'b0;
        st_nxt.rdata        = 32'h0000_0000;
        stat_clr            = 3'h0;
        // pin synchroniser; only the second and third stages feed logic
        st_nxt.rx_meta      = can_rx;
        st_nxt.rx_sync      = st_r.rx_meta;
        st_nxt.rx_prev      = st_r.rx_sync;

        // register writes
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                `CBT_OFF_CTRL:
                begin
                    st_nxt.init                 = bus_req.wdata[`CBT_CTRL_INIT];
                    st_nxt.config_change_enable = bus_req.wdata[`CBT_CTRL_CCE];
                    // leaving init after bus-off restarts confinement from zero
                    if (st_r.bus_off && !bus_req.wdata[`CBT_CTRL_INIT])
                    begin
                        st_nxt.bus_off        = 1'b0;
                        st_nxt.tx_fault_tally = 8'h00;
                        st_nxt.rx_fault_tally            = 8'h00;
                    end
                end
                `CBT_OFF_BTIME:
                begin
                    if (st_r.init && st_r.config_change_enable)
                        st_nxt.btime = bus_req.wdata[`CBT_BTIME_MSB:0];
                end
                `CBT_OFF_IRQ_MASK:
                    st_nxt.irq_mask = bus_req.wdata[`CBT_IRQ_W-1:0];
                default:
                    st_nxt.irq_mask = st_r.irq_mask;
            endcase
        end

        // register reads, data stand one cycle later; unmapped reads zero
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `CBT_OFF_CTRL:
                begin
                    st_nxt.rdata[`CBT_CTRL_INIT] = st_r.init;
                    st_nxt.rdata[`CBT_CTRL_CCE]  = st_r.config_change_enable;
                end
                `CBT_OFF_FAULT:
                begin
                    st_nxt.rdata[`CBT_TEC_MSB:0] = st_r.tx_fault_tally;
                    // the internal tally runs to 128; the field stops at 127
                    st_nxt.rdata[`CBT_REC_MSB:`CBT_REC_LSB] =
                        (st_r.rx_fault_tally >= `CBT_REC_PASSIVE) ? 7'h7F : st_r.rx_fault_tally[6:0];
                    st_nxt.rdata[`CBT_RP_BIT] = (st_r.rx_fault_tally >= `CBT_REC_PASSIVE);
                end
                `CBT_OFF_BTIME:
                    st_nxt.rdata[`CBT_BTIME_MSB:0] = st_r.btime;
                `CBT_OFF_IRQ_STAT:
                begin
                    st_nxt.rdata[`CBT_IRQ_W-1:0] = st_r.irq_stat;
                    stat_clr = st_r.irq_stat;
                end
                `CBT_OFF_IRQ_MASK:
                    st_nxt.rdata[`CBT_IRQ_W-1:0] = st_r.irq_mask;
                default:
                    st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // fault confinement; frozen while bus-off
        if (!st_r.bus_off)
        begin
            if (err_ev.tx_err)
            begin
                if (st_r.tx_fault_tally > `CBT_TEC_TOP_OK)
                begin
                    st_nxt.tx_fault_tally = `CBT_TEC_MAX;
                    st_nxt.bus_off        = 1'b1;
                    st_nxt.init           = 1'b1;
                end
                else
                    st_nxt.tx_fault_tally = st_r.tx_fault_tally + `CBT_TEC_STEP;
            end
            else if (err_ev.tx_ok && st_r.tx_fault_tally != 8'h00)
                st_nxt.tx_fault_tally = st_r.tx_fault_tally - 8'h01;

            if (err_ev.rx_err_major)
                st_nxt.rx_fault_tally = (st_r.rx_fault_tally >= `CBT_REC_MAJ_TOP) ? `CBT_REC_PASSIVE
                                                            : st_r.rx_fault_tally + `CBT_TEC_STEP;
            else if (err_ev.rx_err)
                st_nxt.rx_fault_tally = (st_r.rx_fault_tally >= `CBT_REC_PASSIVE) ? `CBT_REC_PASSIVE
                                                            : st_r.rx_fault_tally + 8'h01;
            else if (err_ev.rx_ok)
            begin
                if (st_r.rx_fault_tally >= `CBT_REC_PASSIVE)
                    st_nxt.rx_fault_tally = `CBT_REC_RELOAD;
                else if (st_r.rx_fault_tally != 8'h00)
                    st_nxt.rx_fault_tally = st_r.rx_fault_tally - 8'h01;
            end
        end

        // interrupt events: a set in the same cycle as a read clear wins
        ev[`CBT_IRQ_RX_PASS] = (st_nxt.rx_fault_tally >= `CBT_REC_PASSIVE) && (st_r.rx_fault_tally < `CBT_REC_PASSIVE);
        ev[`CBT_IRQ_WARN]    = ((st_nxt.tx_fault_tally >= `CBT_WARN_LEVEL) &&
                                (st_r.tx_fault_tally < `CBT_WARN_LEVEL)) ||
                               ((st_nxt.rx_fault_tally >= `CBT_WARN_LEVEL) && (st_r.rx_fault_tally < `CBT_WARN_LEVEL));
        ev[`CBT_IRQ_BUS_OFF] = st_nxt.bus_off & ~st_r.bus_off;
        st_nxt.irq_stat      = (st_r.irq_stat & ~stat_clr) | ev;

        // bit timing
        if (st_r.init)
        begin
            st_nxt.presc       = 6'h00;
            st_nxt.tq_cnt      = 5'h00;
            st_nxt.phase       = cbt_pkg::CBT_SYNC;
            st_nxt.resync_done = 1'b0;
        end
        else
        begin
            st_nxt.presc = tq_tick ? 6'h00 : st_r.presc + 6'h01;
            case (st_r.phase)
                cbt_pkg::CBT_SYNC:
                begin
                    if (edge_fall)
                        st_nxt.resync_done = 1'b1;
                    if (tq_tick)
                    begin
                        st_nxt.phase   = cbt_pkg::CBT_SEG1;
                        st_nxt.tq_cnt  = 5'h00;
                        st_nxt.seg_end = {1'b0, st_r.btime.phase_before_sample};
                    end
                end
                cbt_pkg::CBT_SEG1:
                begin
                    // late edge: stretch the segment by the phase error, capped
                    if (edge_fall && !st_r.resync_done)
                    begin
                        st_nxt.resync_done = 1'b1;
                        st_nxt.seg_end = st_r.seg_end +
                            ((st_r.tq_cnt + 5'h01 > jump) ? jump : st_r.tq_cnt + 5'h01);
                    end
                    if (tq_tick)
                    begin
                        if (st_r.tq_cnt >= st_nxt.seg_end)
                        begin
                            st_nxt.phase        = cbt_pkg::CBT_SEG2;
                            st_nxt.tq_cnt       = 5'h00;
                            st_nxt.seg_end      = {2'h0, st_r.btime.phase_after_sample};
                            st_nxt.sample_pulse = 1'b1;
                            st_nxt.rx_bit       = st_r.rx_sync;
                        end
                        else
                            st_nxt.tq_cnt = st_r.tq_cnt + 5'h01;
                    end
                end
                cbt_pkg::CBT_SEG2:
                begin
                    if (edge_fall && !st_r.resync_done && remain < jump)
                    begin
                        // early edge within the jump: it becomes the next sync
                        st_nxt.phase       = cbt_pkg::CBT_SEG1;
                        st_nxt.tq_cnt      = 5'h00;
                        st_nxt.seg_end     = {1'b0, st_r.btime.phase_before_sample};
                        st_nxt.presc       = 6'h00;
                        st_nxt.bit_start   = 1'b1;
                        st_nxt.resync_done = 1'b1;
                    end
                    else
                    begin
                        if (edge_fall && !st_r.resync_done)
                        begin
                            st_nxt.resync_done = 1'b1;
                            st_nxt.seg_end     = st_r.seg_end - jump;
                        end
                        if (tq_tick)
                        begin
                            if (st_r.tq_cnt >= st_nxt.seg_end)
                            begin
                                st_nxt.phase       = cbt_pkg::CBT_SYNC;
                                st_nxt.bit_start   = 1'b1;
                                st_nxt.resync_done = 1'b0;
                            end
                            else
                                st_nxt.tq_cnt = st_r.tq_cnt + 5'h01;
                        end
                    end
                end
                default:
                    st_nxt.phase = cbt_pkg::CBT_SYNC;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register except the level interrupt and tq_tick
    assign bus_rdata    = st_r.rdata;
    assign sample_pulse = st_r.sample_pulse;
    assign rx_bit       = st_r.rx_bit;
    assign bit_start    = st_r.bit_start;
    assign init         = st_r.init;
    assign bus_off      = st_r.bus_off;
    assign irq          = |(st_r.irq_stat & st_r.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks; helpers count quanta since bit start and clocks between ticks
    logic [5:0] h_tq;
    logic       h_ok;
    logic [6:0] h_gap;
    logic       h_hard;

    // an early edge in the after segment restarts the prescaler mid-quantum
    assign h_hard = (st_r.phase == cbt_pkg::CBT_SEG2) && (st_nxt.phase == cbt_pkg::CBT_SEG1);

    // the prescaler leaves init at zero, so the gap count starts at one there
    always_ff @(posedge sys_clk)
    begin
        if (!nrst || st_r.init)
        begin
            h_tq  <= 6'h00;
            h_ok  <= 1'b0;
            h_gap <= 7'h01;
        end
        else
        begin
            // a tick in the bit start cycle is the sync quantum of the new bit
            h_tq  <= (bit_start ? 6'h00 : h_tq) + {5'h00, tq_tick};
            h_ok  <= h_ok | bit_start;
            h_gap <= (tq_tick || h_hard) ? 7'h01 : h_gap + 7'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    tec_read_a: assert property (bus_req.rd && bus_req.addr == `CBT_OFF_FAULT
        |=> bus_rdata[7:0] == $past(st_r.tx_fault_tally)) else $error("tx tally read");
    rec_read_a: assert property (bus_req.rd && bus_req.addr == `CBT_OFF_FAULT
        && !st_r.rx_fault_tally[7] |=> bus_rdata[14:8] == $past(st_r.rx_fault_tally[6:0]))
        else $error("rx tally read");
    // the internal tally stops at the passive marker, so the field never wraps
    rec_cap_a: assert property (st_r.rx_fault_tally <= `CBT_REC_PASSIVE)
        else $error("rx tally above passive marker");
    passive_flag_a: assert property (bus_req.rd && bus_req.addr == `CBT_OFF_FAULT
        |=> bus_rdata[15] == $past(st_r.rx_fault_tally >= `CBT_REC_PASSIVE))
        else $error("passive flag wrong");
    upper_zero_a: assert property ($past(bus_req.rd)
        |-> bus_rdata[31:16] == 16'h0000) else $error("upper bits not zero");
    btime_reset_a: assert property (!$past(nrst) |-> st_r.btime == `CBT_BTIME_RST
        && st_r.tx_fault_tally == 8'h00 && st_r.rx_fault_tally == 8'h00)
        else $error("reset value wrong");
    btime_guard_a: assert property (bus_req.wr && bus_req.addr == `CBT_OFF_BTIME
        && !(init && st_r.config_change_enable) |=> $stable(st_r.btime))
        else $error("timing write taken while locked");
    tq_period_a: assert property (tq_tick && $stable(st_r.btime)
        |-> h_gap == {1'b0, st_r.btime.quantum_prescaler} + 7'h01)
        else $error("quantum length wrong");
    seg1_len_a: assert property (sample_pulse && h_ok && !st_r.resync_done
        |-> h_tq == {2'h0, st_r.btime.phase_before_sample} + 6'h02)
        else $error("sample point misplaced");
    jump_cap_a: assert property (sample_pulse && h_ok |-> h_tq <=
        {2'h0, st_r.btime.phase_before_sample} + {4'h0, st_r.btime.resync_jump_width} + 6'h03)
        else $error("resync beyond jump width");
    bit_len_a: assert property (bit_start && h_ok && !$past(st_r.resync_done)
        && st_r.phase == cbt_pkg::CBT_SYNC |-> h_tq == {2'h0, st_r.btime.phase_before_sample}
        + {3'h0, st_r.btime.phase_after_sample} + 6'h03)
        else $error("bit length wrong");
    tec_step_a: assert property (err_ev.tx_err && !bus_off
        && st_r.tx_fault_tally <= `CBT_TEC_TOP_OK
        |=> st_r.tx_fault_tally == $past(st_r.tx_fault_tally) + `CBT_TEC_STEP)
        else $error("tx tally step wrong");

    sample_seen_c:  cover property (sample_pulse && h_ok);
    hard_sync_c:    cover property (bit_start && st_r.phase == cbt_pkg::CBT_SEG1);
    resync_seen_c:  cover property (sample_pulse && st_r.resync_done);
    bus_off_c:      cover property ($rose(bus_off));
    btime_write_c:  cover property (bus_req.wr && bus_req.addr == `CBT_OFF_BTIME
                                    && init && st_r.config_change_enable);

endmodule : cbt_top

/* File: verif/cbt_bus_node.sv */
// far side of the bus: another node driving the receive line
module cbt_bus_node
(
    // clock used to pace bit lengths
    input  wire logic sys_clk,
    // bus line as seen by the block, recessive high
    output logic      can_rx
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////
    // the bus idles recessive through its termination, so release means one
    initial can_rx = 1'b1;

    // send msb first, each bit held a whole number of clocks; call at an edge
    task automatic send_bits(input logic [11:0] bits, input int clks);
        for (int i = 11; i >= 0; i--)
        begin
            can_rx <= bits[i];
            repeat (clks) @(posedge sys_clk);
        end
        can_rx <= 1'b1;
    endtask : send_bits
endmodule : cbt_bus_node

/* File: verif/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  sys_clk = 1'b0;
    logic                  nrst    = 1'b0;
    cbt_pkg::cbt_bus_req_s bus_req = '0;
    cbt_pkg::cbt_err_ev_s  err_ev  = '0;
    logic                  can_rx;
    logic [31:0]           bus_rdata;
    logic                  sample_pulse;
    logic                  rx_bit;
    logic                  bit_start;
    logic                  tq_tick;
    logic                  init;
    logic                  bus_off;
    logic                  irq;
    int                    failures = 0;
    int                    checked  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    cbt_top i_cbt_top (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .err_ev(err_ev), .can_rx(can_rx),
        .sample_pulse(sample_pulse), .rx_bit(rx_bit), .bit_start(bit_start),
        .tq_tick(tq_tick), .init(init), .bus_off(bus_off), .irq(irq));

    cbt_bus_node i_node (.sys_clk(sys_clk), .can_rx(can_rx));

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // one-cycle write; settle a little so flags can be looked at on return
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk32(bus_rdata, exp);
    endtask : rd_chk

    task automatic pulse(input cbt_pkg::cbt_err_ev_s ev, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            err_ev <= ev;
            @(posedge sys_clk);
            err_ev <= '0;
        end
        #1;
    endtask : pulse

    // clocks and quantum ticks up to the next sample pulse, bounded against a hang
    task automatic wait_sample(output int n, output int q);
        n = 0;
        q = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (tq_tick === 1'b1)
                q++;
        end
        while (sample_pulse !== 1'b1 && n < 2000);
    endtask : wait_sample

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk(8'h0C, 32'h0000_2301);
        rd_chk(8'h08, 32'h0000_0000);
        rd_chk(8'h10, 32'h0000_0000);
    endtask : t_reset

    // timing stays locked until init and change enable are both set
    task automatic t_lock;
        reg_wr(8'h0C, 32'h0000_1234);
        rd_chk(8'h0C, 32'h0000_2301);
        reg_wr(8'h00, 32'h0000_0041);
        reg_wr(8'h0C, 32'h0000_7FFF);
        rd_chk(8'h0C, 32'h0000_7FFF);
        reg_wr(8'h08, 32'h0000_0055);
        rd_chk(8'h08, 32'h0000_0000);
    endtask : t_lock

    // bit period is (prescaler+1) * (1 + before+1 + after+1) clocks, the bracket in quanta
    task automatic t_timing;
        logic [31:0] cfg [3] = '{32'h0000_0100, 32'h0000_7F02, 32'h0000_2301};
        int          per [3] = '{4, 75, 16};
        int          qpb [3] = '{4, 25, 8};
        int          n;
        int          q;
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(8'h00, 32'h0000_0041);
            reg_wr(8'h0C, cfg[i]);
            reg_wr(8'h00, 32'h0000_0000);
            wait_sample(n, q);
            wait_sample(n, q);
            chk32(32'(n), 32'(per[i]));
            chk32(32'(q), 32'(qpb[i]));
        end
    endtask : t_timing

    // frame from the far node, launched right after a bit start
    task automatic t_rx;
        logic [11:0] got;
        int          n;
        int          q;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (bit_start !== 1'b1 && n < 200);
        @(posedge sys_clk);
        fork
            i_node.send_bits(12'h35C, 16);
            for (int k = 11; k >= 0; k--)
            begin
                wait_sample(n, q);
                got[k] = rx_bit;
            end
        join
        chk32({20'h0, got}, 32'h0000_035C);
    endtask : t_rx

    task automatic t_faults;
        reg_wr(8'h24, 32'h0000_0007);
        pulse(5'h10, 3);
        pulse(5'h02, 1);
        rd_chk(8'h08, 32'h0000_0017);
        pulse(5'h04, 16);
        rd_chk(8'h08, 32'h0000_FF17);
        chk1(irq, 1'b1);
        rd_chk(8'h20, 32'h0000_0003);
        chk1(irq, 1'b0);
        pulse(5'h01, 1);
        rd_chk(8'h08, 32'h0000_7717);
        pulse(5'h08, 1);
        rd_chk(8'h08, 32'h0000_7817);
    endtask : t_faults

    // tally tops out at 255, one more error takes the node off the bus
    task automatic t_busoff;
        pulse(5'h10, 29);
        rd_chk(8'h08, 32'h0000_78FF);
        chk1(bus_off, 1'b0);
        pulse(5'h10, 1);
        chk1(bus_off, 1'b1);
        chk1(init, 1'b1);
        pulse(5'h02, 1);
        rd_chk(8'h08, 32'h0000_78FF);
        chk1(irq, 1'b1);
        rd_chk(8'h20, 32'h0000_0006);
        reg_wr(8'h00, 32'h0000_0000);
        chk1(bus_off, 1'b0);
        rd_chk(8'h08, 32'h0000_0000);
    endtask : t_busoff

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_lock();
        t_timing();
        t_rx();
        t_faults();
        t_busoff();
        complete_run();
    end

    // the whole run needs well under a thousand clocks; far beyond that means a hang
    initial
    begin
        #(20000 * 25);
        failures++;
        complete_run();
    end
endmodule : tb
